// [bench/core_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Processor core issuing register instructions
module core_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] addr,
	output logic wr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		wdata = 8'h00;
	end
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic sel_ctrl();
		put(nv_access_pkg::PTR_ONE_ADDR, nv_access_pkg::CTRL_OFFSET);
		put(nv_access_pkg::BANK_ADDR, 8'h01);
	endtask
	// Bounded poll until hardware drops a trigger
	task automatic poll(input int b, output logic ok);
		logic [7:0] v;
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			get(nv_access_pkg::PORT_ONE_ADDR, v);
			ok = (v[b] === 1'b0);
		end
	endtask
	task automatic prog(input logic [7:0] loc, input logic [7:0] d);
		put(nv_access_pkg::LOC_ADDR, loc);
		put(nv_access_pkg::BYTE_ADDR, d);
		sel_ctrl();
		put(nv_access_pkg::PORT_ONE_ADDR, 8'h08);
		put(nv_access_pkg::PORT_ONE_ADDR, 8'h0c);
	endtask
	task automatic fetch(input logic [7:0] loc, output logic [7:0] d, output logic ok);
		put(nv_access_pkg::PORT_ONE_ADDR, 8'h02);
		put(nv_access_pkg::LOC_ADDR, loc);
		put(nv_access_pkg::PORT_ONE_ADDR, 8'h03);
		poll(nv_access_pkg::FETCH_GO_BIT, ok);
		get(nv_access_pkg::BYTE_ADDR, d);
	endtask
endmodule

// [bench/eeprom_data_memory_access_test.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module eeprom_data_memory_access_test;
	localparam logic [7:0] CP = nv_access_pkg::PORT_ONE_ADDR;
	localparam logic [7:0] LA = nv_access_pkg::LOC_ADDR;
	localparam logic [7:0] BA = nv_access_pkg::BYTE_ADDR;
	logic clk, rst, wdt, clr, ack, wr, done, shared, ok;
	logic [7:0] addr, wdata, rdata, v;
	logic [1:0] bank;
	int n_mismatch = 0;
	int total_checks = 0;
	nv_access dut (.REF_CLK(clk), .RESET(rst), .WDT_PD_RESET(wdt), .SFR_ADDR(addr),
		.SFR_WR(wr), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .NV_DONE_FLAG_CLR(clr),
		.SHARED_FLAG_ACK(ack), .NV_DONE_FLAG(done), .SHARED_FLAG(shared),
		.BANK_SELECTOR(bank));
	core_model cpu (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rdata(rdata));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset_state();
		`CHK(bank, 2'h0)
		`CHK({done, shared}, 2'h0)
		cpu.put(CP, 8'h08);
		cpu.sel_ctrl();
		cpu.get(CP, v);
		`CHK(v, 8'h00)
		cpu.put(CP, 8'hf2);
		cpu.get(CP, v);
		`CHK(v, 8'h02)
	endtask
	task automatic t_regs();
		cpu.put(LA, 8'hff);
		cpu.get(LA, v);
		`CHK(v, 8'h7f)
		cpu.put(BA, 8'ha5);
		cpu.get(BA, v);
		`CHK(v, 8'ha5)
		cpu.get(nv_access_pkg::BANK_ADDR, v);
		`CHK(v, 8'h01)
		cpu.get(nv_access_pkg::PTR_ONE_ADDR, v);
		`CHK(v, 8'h40)
	endtask
	task automatic t_no_permit();
		cpu.put(CP, 8'h00);
		cpu.put(CP, 8'h0c);
		cpu.get(CP, v);
		`CHK(v, 8'h08)
		cpu.put(CP, 8'h03);
		cpu.get(CP, v);
		`CHK(v, 8'h02)
		repeat (200) @(posedge clk);
		@(negedge clk);
		`CHK(done, 1'b0)
	endtask
	task automatic t_write();
		cpu.prog(8'h7f, 8'h5a);
		cpu.get(CP, v);
		`CHK(v, 8'h0c)
		cpu.put(CP, 8'h0e);
		cpu.put(CP, 8'h0b);
		cpu.get(CP, v);
		`CHK(v, 8'h0e)
		cpu.poll(nv_access_pkg::PROG_GO_BIT, ok);
		`CHK(ok, 1'b1)
		if (!ok) end_sim();
		`CHK({done, shared}, 2'h3)
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		@(negedge clk);
		`CHK({done, shared}, 2'h2)
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		@(negedge clk);
		`CHK(done, 1'b0)
	endtask
	task automatic t_read();
		cpu.put(BA, 8'h00);
		cpu.fetch(8'h7f, v, ok);
		`CHK(ok, 1'b1)
		if (!ok) end_sim();
		`CHK(v, 8'h5a)
		cpu.get(CP, v);
		`CHK(v, 8'h02)
		repeat (20) @(posedge clk);
		cpu.get(BA, v);
		`CHK(v, 8'h5a)
	endtask
	task automatic t_wdt();
		@(posedge clk);
		wdt <= 1'b1;
		cpu.put(nv_access_pkg::BANK_ADDR, 8'h00);
		@(negedge clk);
		`CHK(bank, 2'h1)
		@(posedge clk);
		wdt <= 1'b0;
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(bank, 2'h0)
		cpu.sel_ctrl();
		cpu.get(CP, v);
		`CHK(v, 8'h00)
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		wdt = 1'b0;
		clr = 1'b0;
		ack = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset_state();
		t_regs();
		t_no_permit();
		t_write();
		t_read();
		t_wdt();
		end_sim();
	end
endmodule

// [core/nv_access.sv]
`timescale 1ns/1ns
module nv_access #(
	parameter int ADDR_W = 7
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic WDT_PD_RESET,
	// Special function register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// Flag servicing and bank selector
	input wire logic NV_DONE_FLAG_CLR,
	input wire logic SHARED_FLAG_ACK,
	output logic NV_DONE_FLAG,
	output logic SHARED_FLAG,
	output logic [1:0] BANK_SELECTOR
);
	localparam int DEPTH = 1 << ADDR_W;
	// Write completion window, in cycles after launch
	localparam int PROG_MIN = nv_access_pkg::TICK_DIV * (nv_access_pkg::PROG_TICKS - 1) + 2;
	localparam int PROG_MAX = nv_access_pkg::TICK_DIV * nv_access_pkg::PROG_TICKS + 1;

	logic [7:0] mem [DEPTH];
	logic [ADDR_W-1:0] loc_ff, nxt_loc;
	logic [7:0] val_ff, nxt_val;
	logic [3:0] ctrl_ff, nxt_ctrl;
	logic [7:0] ptr_ff, nxt_ptr;
	logic [1:0] bank_ff, nxt_bank;
	logic done_ff, nxt_done;
	logic shared_ff, nxt_shared;
	nv_access_pkg::seq_t st_ff, nxt_st;
	logic [3:0] fcnt_ff, nxt_fcnt;
	logic prog_start, prog_done, mem_we;

	// ==========================================================
	// Decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction

	logic ctrl_sel, ctrl_wr;
	assign ctrl_sel = hit(SFR_ADDR, nv_access_pkg::PORT_ONE_ADDR)
		&& hit(ptr_ff, nv_access_pkg::CTRL_OFFSET)
		&& bank_ff == nv_access_pkg::CTRL_BANK;
	assign ctrl_wr = SFR_WR && ctrl_sel;

	// ==========================================================
	// Write timer
	assign prog_start = st_ff == nv_access_pkg::ST_IDLE && nxt_st == nv_access_pkg::ST_PROG;

	nv_prog_timer #(
		.DIV(nv_access_pkg::TICK_DIV),
		.TICKS(nv_access_pkg::PROG_TICKS)
	) u_timer (
		.clk(REF_CLK),
		.rst(RESET),
		.start(prog_start),
		.done(prog_done)
	);

	// ==========================================================
	// Registers and sequencer
	logic go_prog, go_fetch;
	logic [3:0] wc;
	assign wc = SFR_WDATA[3:0];
	// Permit must already stand before the trigger write
	assign go_prog = ctrl_wr && wc[nv_access_pkg::PROG_GO_BIT]
		&& ctrl_ff[nv_access_pkg::PROG_PERMIT_BIT] && wc[nv_access_pkg::PROG_PERMIT_BIT];
	assign go_fetch = ctrl_wr && wc[nv_access_pkg::FETCH_GO_BIT]
		&& ctrl_ff[nv_access_pkg::FETCH_PERMIT_BIT] && wc[nv_access_pkg::FETCH_PERMIT_BIT];

	always_comb begin
		nxt_loc = loc_ff;
		nxt_val = val_ff;
		nxt_ctrl = ctrl_ff;
		nxt_ptr = ptr_ff;
		nxt_bank = bank_ff;
		nxt_st = st_ff;
		nxt_fcnt = fcnt_ff;
		nxt_done = done_ff;
		nxt_shared = shared_ff;
		mem_we = 1'b0;
		if (SFR_WR) begin
			if (hit(SFR_ADDR, nv_access_pkg::LOC_ADDR))
				nxt_loc = SFR_WDATA[ADDR_W-1:0];
			if (hit(SFR_ADDR, nv_access_pkg::BYTE_ADDR) && st_ff != nv_access_pkg::ST_FETCH)
				nxt_val = SFR_WDATA;
			if (hit(SFR_ADDR, nv_access_pkg::PTR_ONE_ADDR))
				nxt_ptr = SFR_WDATA;
			if (hit(SFR_ADDR, nv_access_pkg::BANK_ADDR))
				nxt_bank = SFR_WDATA[1:0];
		end
		// Bank kept through a watchdog wake from power-down
		if (WDT_PD_RESET)
			nxt_bank = bank_ff;
		if (ctrl_wr) begin
			// Triggers stay under hardware control once raised
			nxt_ctrl[nv_access_pkg::PROG_PERMIT_BIT] = wc[nv_access_pkg::PROG_PERMIT_BIT];
			nxt_ctrl[nv_access_pkg::FETCH_PERMIT_BIT] = wc[nv_access_pkg::FETCH_PERMIT_BIT];
		end
		unique case (st_ff)
			nv_access_pkg::ST_IDLE: begin
				if (go_prog && !go_fetch) begin
					nxt_ctrl[nv_access_pkg::PROG_GO_BIT] = 1'b1;
					nxt_st = nv_access_pkg::ST_PROG;
				end else if (go_fetch && !go_prog) begin
					nxt_ctrl[nv_access_pkg::FETCH_GO_BIT] = 1'b1;
					nxt_fcnt = 4'h0;
					nxt_st = nv_access_pkg::ST_FETCH;
				end
			end
			nv_access_pkg::ST_FETCH: begin
				if (fcnt_ff == 4'(nv_access_pkg::FETCH_CYCLES - 1)) begin
					nxt_val = mem[loc_ff];
					nxt_ctrl[nv_access_pkg::FETCH_GO_BIT] = 1'b0;
					nxt_st = nv_access_pkg::ST_IDLE;
				end else begin
					nxt_fcnt = fcnt_ff + 4'h1;
				end
			end
			nv_access_pkg::ST_PROG: begin
				// New triggers are not honoured here
				if (prog_done) begin
					mem_we = 1'b1;
					nxt_ctrl[nv_access_pkg::PROG_GO_BIT] = 1'b0;
					nxt_st = nv_access_pkg::ST_IDLE;
				end
			end
			default: nxt_st = nv_access_pkg::ST_IDLE;
		endcase
		// Set wins over a same-cycle clear
		if (NV_DONE_FLAG_CLR)
			nxt_done = 1'b0;
		if (SHARED_FLAG_ACK)
			nxt_shared = 1'b0;
		if (mem_we) begin
			nxt_done = 1'b1;
			nxt_shared = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_ff <= nv_access_pkg::CTRL_RESET;
			ptr_ff <= 8'h00;
			st_ff <= nv_access_pkg::ST_IDLE;
			fcnt_ff <= 4'h0;
			done_ff <= 1'b0;
			shared_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			ptr_ff <= nxt_ptr;
			st_ff <= nxt_st;
			fcnt_ff <= nxt_fcnt;
			done_ff <= nxt_done;
			shared_ff <= nxt_shared;
		end
	end

	// Bank selector cleared by power-on reset only
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET)
			bank_ff <= nv_access_pkg::BANK_RESET;
		else
			bank_ff <= nxt_bank;
	end

	// Location, byte value and array carry no reset
	always_ff @(posedge REF_CLK) begin
		loc_ff <= nxt_loc;
		val_ff <= nxt_val;
		if (mem_we)
			mem[loc_ff] <= val_ff;
	end

	// ==========================================================
	// Read mux
	always_comb begin
		SFR_RDATA = 8'h00;
		if (hit(SFR_ADDR, nv_access_pkg::LOC_ADDR))
			SFR_RDATA = 8'(loc_ff);
		else if (hit(SFR_ADDR, nv_access_pkg::BYTE_ADDR))
			SFR_RDATA = val_ff;
		else if (hit(SFR_ADDR, nv_access_pkg::PTR_ONE_ADDR))
			SFR_RDATA = ptr_ff;
		else if (hit(SFR_ADDR, nv_access_pkg::BANK_ADDR))
			SFR_RDATA = {6'h00, bank_ff};
		else if (ctrl_sel)
			SFR_RDATA = {4'h0, ctrl_ff};
	end

	assign NV_DONE_FLAG = done_ff;
	assign SHARED_FLAG = shared_ff;
	assign BANK_SELECTOR = bank_ff;

	// ==========================================================
	// Checks
	sequence fetch_launch;
		st_ff == nv_access_pkg::ST_IDLE && go_fetch && !go_prog;
	endsequence
	sequence fetch_end;
		!ctrl_ff[nv_access_pkg::FETCH_GO_BIT];
	endsequence

	AST_FETCH_DONE: assert property (@(posedge REF_CLK) disable iff (RESET)
		fetch_launch |=> ctrl_ff[nv_access_pkg::FETCH_GO_BIT] ##[1:8] fetch_end)
		else $error("read trigger did not self-clear");
	AST_PROG_NEEDS_PERMIT: assert property (@(posedge REF_CLK) disable iff (RESET)
		ctrl_wr && !ctrl_ff[nv_access_pkg::PROG_PERMIT_BIT] |=> st_ff != nv_access_pkg::ST_PROG
		|| $past(st_ff) == nv_access_pkg::ST_PROG)
		else $error("write started without permit");
	AST_FETCH_NEEDS_PERMIT: assert property (@(posedge REF_CLK) disable iff (RESET)
		$rose(ctrl_ff[nv_access_pkg::FETCH_GO_BIT]) |-> $past(ctrl_ff[nv_access_pkg::FETCH_PERMIT_BIT]))
		else $error("read started without permit");
	AST_PROG_PERMIT: assert property (@(posedge REF_CLK) disable iff (RESET)
		$rose(ctrl_ff[nv_access_pkg::PROG_GO_BIT]) |-> $past(ctrl_ff[nv_access_pkg::PROG_PERMIT_BIT]))
		else $error("write trigger set without permit");
	AST_DONE_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
		$fell(ctrl_ff[nv_access_pkg::PROG_GO_BIT]) |-> done_ff && shared_ff)
		else $error("completion flags not set");
	AST_PROG_HOLDOFF: assert property (@(posedge REF_CLK) disable iff (RESET)
		st_ff == nv_access_pkg::ST_PROG |=> !$rose(ctrl_ff[nv_access_pkg::FETCH_GO_BIT]))
		else $error("read launched during write");
	AST_CTRL_UPPER: assert property (@(posedge REF_CLK) disable iff (RESET)
		ctrl_sel |-> SFR_RDATA[7:4] == 4'h0)
		else $error("control upper nibble not zero");
	AST_VALUE_HELD: assert property (@(posedge REF_CLK) disable iff (RESET)
		$fell(ctrl_ff[nv_access_pkg::FETCH_GO_BIT]) && !(SFR_WR
		&& SFR_ADDR == nv_access_pkg::BYTE_ADDR) && st_ff == nv_access_pkg::ST_IDLE
		|=> $stable(val_ff))
		else $error("fetched byte changed");
	AST_PROG_CLEARS: assert property (@(posedge REF_CLK) disable iff (RESET)
		prog_done && st_ff == nv_access_pkg::ST_PROG |=> !ctrl_ff[nv_access_pkg::PROG_GO_BIT])
		else $error("write trigger not cleared on completion");

	// ==========================================================
	// Completion, flags and data path
	sequence prog_launch;
		st_ff == nv_access_pkg::ST_IDLE && go_prog && !go_fetch;
	endsequence
	sequence prog_end;
		!ctrl_ff[nv_access_pkg::PROG_GO_BIT] && done_ff && shared_ff;
	endsequence

	AST_PROG_START: assert property (@(posedge REF_CLK) disable iff (RESET)
		prog_launch |=> ctrl_ff[nv_access_pkg::PROG_GO_BIT] && st_ff == nv_access_pkg::ST_PROG)
		else $error("write trigger did not launch a cycle");
	AST_PROG_FINISH: assert property (@(posedge REF_CLK) disable iff (RESET)
		prog_launch |=> ##[PROG_MIN:PROG_MAX] prog_end)
		else $error("write cycle did not end in its window");
	AST_FETCH_LAUNCH: assert property (@(posedge REF_CLK) disable iff (RESET)
		fetch_launch |=> ctrl_ff[nv_access_pkg::FETCH_GO_BIT] && st_ff == nv_access_pkg::ST_FETCH)
		else $error("read trigger did not launch a read");
	AST_DONE_STICKY: assert property (@(posedge REF_CLK) disable iff (RESET)
		done_ff && !NV_DONE_FLAG_CLR |=> done_ff)
		else $error("completion flag dropped without clear");
	AST_SHARED_STICKY: assert property (@(posedge REF_CLK) disable iff (RESET)
		shared_ff && !SHARED_FLAG_ACK |=> shared_ff)
		else $error("shared flag dropped without service");
	AST_SHARED_CLEAR: assert property (@(posedge REF_CLK) disable iff (RESET)
		SHARED_FLAG_ACK && !mem_we |=> !shared_ff)
		else $error("shared flag not cleared by service");
	AST_BANK_FROZEN: assert property (@(posedge REF_CLK) disable iff (RESET)
		WDT_PD_RESET |=> $stable(bank_ff))
		else $error("bank changed during watchdog wake");
	AST_ARRAY_WRITE: assert property (@(posedge REF_CLK) disable iff (RESET)
		mem_we |=> mem[$past(loc_ff)] == $past(val_ff))
		else $error("array byte not written");
	AST_FETCH_LOAD: assert property (@(posedge REF_CLK) disable iff (RESET)
		st_ff == nv_access_pkg::ST_FETCH
		&& fcnt_ff == 4'(nv_access_pkg::FETCH_CYCLES - 1) |=> val_ff == $past(mem[loc_ff]))
		else $error("fetched byte not loaded");
	AST_VALUE_LOCKED: assert property (@(posedge REF_CLK) disable iff (RESET)
		st_ff == nv_access_pkg::ST_FETCH
		&& fcnt_ff != 4'(nv_access_pkg::FETCH_CYCLES - 1) |=> $stable(val_ff))
		else $error("byte value changed during read");
	AST_LOC_UPPER: assert property (@(posedge REF_CLK) disable iff (RESET)
		hit(SFR_ADDR, nv_access_pkg::LOC_ADDR) |-> (SFR_RDATA >> ADDR_W) == 8'h00)
		else $error("location upper bits not zero");
	AST_PERMIT_WRITE: assert property (@(posedge REF_CLK) disable iff (RESET)
		ctrl_wr |=> ctrl_ff[nv_access_pkg::PROG_PERMIT_BIT]
		== $past(SFR_WDATA[nv_access_pkg::PROG_PERMIT_BIT]))
		else $error("write permit not taken as written");
endmodule

// [core/nv_access_pkg.sv]
package nv_access_pkg;
	// ==========================================================
	// Special function addresses
	localparam logic [7:0] LOC_ADDR = 8'h2a;
	localparam logic [7:0] BYTE_ADDR = 8'h2b;
	localparam logic [7:0] PTR_ONE_ADDR = 8'h03;
	localparam logic [7:0] PORT_ONE_ADDR = 8'h02;
	localparam logic [7:0] BANK_ADDR = 8'h04;
	localparam logic [7:0] CTRL_OFFSET = 8'h40;
	localparam logic [1:0] CTRL_BANK = 2'h1;
	// ==========================================================
	// Control field positions
	localparam int FETCH_GO_BIT = 0;
	localparam int FETCH_PERMIT_BIT = 1;
	localparam int PROG_GO_BIT = 2;
	localparam int PROG_PERMIT_BIT = 3;
	// ==========================================================
	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [1:0] BANK_RESET = 2'h0;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int FETCH_NS = 8;
	localparam int FETCH_CYCLES = (FETCH_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_TICKS = 8;
	localparam int TICK_DIV = 16;
	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_PROG = 2'b11
	} seq_t;
endpackage

// [core/nv_prog_timer.sv]
`timescale 1ns/1ns
// Write timer with a free-running prescaler, started by the access sequencer
module nv_prog_timer #(
	parameter int DIV = 16,
	parameter int TICKS = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);
	logic [7:0] div_ff, nxt_div;
	logic [7:0] cnt_ff, nxt_cnt;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic tick;

	assign tick = (div_ff == 8'(DIV - 1));
	assign done = done_ff;

	always_comb begin
		nxt_div = tick ? 8'h00 : div_ff + 8'h01;
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (start && !busy_ff) begin
			nxt_busy = 1'b1;
			nxt_cnt = 8'h00;
		end else if (busy_ff && tick) begin
			if (cnt_ff == 8'(TICKS - 1)) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_ff <= 8'h00;
			cnt_ff <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end
endmodule
